// [prog_resp_defines.svh]
// constants of the programming-mode command responder
// assumes a 40 MHz core clock; included by the package user files
`ifndef PROG_RESP_DEFINES_SVH
`define PROG_RESP_DEFINES_SVH

// -----------------------------------------------------------------
// response codes and fixed data words
// -----------------------------------------------------------------
`define RC_OK 10'h1e1
`define RC_ERR 10'h1e2
`define WORD_EXEC_OK 10'h2aa
`define WORD_ENTRY_OK 10'h0ca

// -----------------------------------------------------------------
// error numbers
// -----------------------------------------------------------------
`define ERR_FRAMING 4'h1
`define ERR_CRC 4'h2
`define ERR_RANGE 4'h5
`define ERR_WPROT 4'h6

// -----------------------------------------------------------------
// frame fields
// -----------------------------------------------------------------
`define FC_READ 3'h2
`define FC_WRITE 3'h3
`define FC_EXEC 3'h4
`define FC_ENTRY 3'h7
`define OWN_SENSOR_ADDRESS_FIELD 3'h1
`define START_SEQ 3'h2
`define CRC_SEED 3'h7
`define CRC_POLY 3'h3
`define SHORT_LEN 6'h0f
`define LONG_LEN 6'h1d
`define PAY_MAX 5'h13

// -----------------------------------------------------------------
// array layout
// -----------------------------------------------------------------
`define STATUS_BYTE 5'h00
`define LOCK_BYTE 4'h1
`define LOCK_BIT 7
`define SHADOW_RST 8'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_NS 25
`define GAP_NS 32000
`define GAP_CYC ((`GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_DELAY_NS 1000000
`define PROG_DELAY_CYC ((`PROG_DELAY_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_BIT_NS 100000
`define PROG_BIT_CYC ((`PROG_BIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [prog_resp_pkg.sv]
// types of the programming-mode command responder
// assumes nothing of its surroundings
package prog_resp_pkg;
  typedef enum logic {RX_IDLE = 1'b0, RX_BITS = 1'b1} rx_state_t;
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_DELAY = 2'b01,
    P_WRITE = 2'b11,
    P_DONE = 2'b10
  } prog_state_t;
  typedef logic [9:0] resp_word_t;
endpackage

// [crc3_divider.sv]
// serial three-bit crc divider for command payload bits
// assumes payload bits arrive in received order, crc bits last
`timescale 1ns/1ps
`include "prog_resp_defines.svh"
module crc3_divider (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic init_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [2:0] rem_o
);
  logic [2:0] rem_ff;
  logic [2:0] nxt_rem;

  // -----------------------------------------------------------------
  // division step
  // -----------------------------------------------------------------
  // seeded x^3+x+1
  // feeding the received crc after the data leaves zero on a match,
  // which equals the three-zero augmented compare
  always_comb begin
    nxt_rem = rem_ff;
    if (init_i) begin
      nxt_rem = `CRC_SEED;
    end else if (shift_i) begin
      nxt_rem = {rem_ff[1:0], bit_i} ^ (rem_ff[2] ? `CRC_POLY : 3'h0);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rem_ff <= `CRC_SEED;
    end else begin
      rem_ff <= nxt_rem;
    end
  end

  assign rem_o = rem_ff;
endmodule

// [prog_mode_command_responder.sv]
// programming-mode command interpreter with nibble array and otp model
// assumes a bit layer that delivers decoded command bits and sync pulses
`timescale 1ns/1ps
`include "prog_resp_defines.svh"
module prog_mode_command_responder
  import prog_resp_pkg::*;
#(
  parameter int ARRAY_BYTES = 16,
  parameter int PROG_DELAY_CYC = `PROG_DELAY_CYC,
  parameter int PROG_BIT_CYC = `PROG_BIT_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_bit_valid_i,
  input wire logic cmd_bit_i,
  input wire logic sync_pulse_i,
  input wire logic vpp_ok_i,
  output logic tx_start_o,
  output logic [9:0] tx_word_o,
  output logic tx_parity_o,
  output logic prog_busy_o,
  output logic otp_valid_flag_o
);
  localparam int AW = $clog2(ARRAY_BYTES);

  rx_state_t rx_st_ff, nxt_rx_st;
  logic [5:0] pos_ff, nxt_pos;
  logic [2:0] start_ff, nxt_start;
  logic [18:0] pay_ff, nxt_pay;
  logic [4:0] pay_cnt_ff, nxt_pay_cnt;
  logic fail_ff, nxt_fail;
  logic [10:0] gap_ff, nxt_gap;
  logic frame_done, crc_init, crc_shift;
  logic [2:0] crc_rem;

  // -----------------------------------------------------------------
  // command bit reception
  // -----------------------------------------------------------------
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_pos = pos_ff;
    nxt_start = start_ff;
    nxt_pay = pay_ff;
    nxt_pay_cnt = pay_cnt_ff;
    nxt_fail = fail_ff;
    nxt_gap = gap_ff;
    frame_done = 1'b0;
    crc_init = 1'b0;
    crc_shift = 1'b0;
    if (cmd_bit_valid_i) begin
      nxt_gap = 11'h000;
      if (rx_st_ff == RX_IDLE) begin
        nxt_rx_st = RX_BITS;
        nxt_pos = 6'h01;
        nxt_start = {2'b00, cmd_bit_i};
        nxt_pay_cnt = 5'h00;
        nxt_fail = 1'b0;
        crc_init = 1'b1;
      end else begin
        if (pos_ff != 6'h3f) begin
          nxt_pos = pos_ff + 6'h01;
        end
        if (pos_ff < 6'h03) begin
          nxt_start = {start_ff[1:0], cmd_bit_i};
        end else if (pos_ff[1:0] == 2'b11) begin
          if (!cmd_bit_i) begin
            nxt_fail = 1'b1;
          end
        end else begin
          crc_shift = 1'b1;
          if (pay_cnt_ff < `PAY_MAX) begin
            nxt_pay[pay_cnt_ff] = cmd_bit_i;
            nxt_pay_cnt = pay_cnt_ff + 5'h01;
          end
        end
      end
    end else if (rx_st_ff == RX_BITS) begin
      // an idle gap closes the frame; the bit count in pos_ff decides the type
      if (gap_ff == 11'(`GAP_CYC - 1)) begin
        frame_done = 1'b1;
        nxt_rx_st = RX_IDLE;
        nxt_gap = 11'h000;
      end else begin
        nxt_gap = gap_ff + 11'h001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st_ff <= RX_IDLE;
      pos_ff <= 6'h00;
      start_ff <= 3'h0;
      pay_ff <= 19'h00000;
      pay_cnt_ff <= 5'h00;
      fail_ff <= 1'b0;
      gap_ff <= 11'h000;
    end else begin
      rx_st_ff <= nxt_rx_st;
      pos_ff <= nxt_pos;
      start_ff <= nxt_start;
      pay_ff <= nxt_pay;
      pay_cnt_ff <= nxt_pay_cnt;
      fail_ff <= nxt_fail;
      gap_ff <= nxt_gap;
    end
  end

  crc3_divider u_crc (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .init_i(crc_init),
    .shift_i(crc_shift),
    .bit_i(cmd_bit_i),
    .rem_o(crc_rem)
  );

  // -----------------------------------------------------------------
  // array read helpers
  // -----------------------------------------------------------------
  logic [7:0] shadow_ff [ARRAY_BYTES];
  logic [7:0] otp_ff [ARRAY_BYTES];
  logic [7:0] nxt_shadow [ARRAY_BYTES];
  logic [7:0] nxt_otp [ARRAY_BYTES];
  logic valid_ff, nxt_valid;

  function automatic logic [7:0] rd_byte(input logic [4:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `STATUS_BYTE) begin
      r = {7'h00, valid_ff};
    end else if (int'(a) < ARRAY_BYTES) begin
      r = shadow_ff[a[AW-1:0]];
    end
    return r;
  endfunction

  function automatic logic [15:0] ones_needed();
    logic [15:0] cnt;
    cnt = 16'h0000;
    for (int i = 0; i < ARRAY_BYTES; i++) begin
      for (int b = 0; b < 8; b++) begin
        cnt = cnt + 16'(shadow_ff[i][b] & ~otp_ff[i][b]);
      end
    end
    return cnt;
  endfunction

  // -----------------------------------------------------------------
  // frame decode
  // -----------------------------------------------------------------
  logic [2:0] sensor_address_field, fc;
  logic [5:0] na;
  logic [4:0] bidx;
  logic [7:0] cur, merged;
  logic in_range, locked, err, wr_en, exec_go;
  logic [3:0] error_number;
  logic [1:0] dec_n;
  resp_word_t dec_w0, dec_w1, dec_w2;
  prog_state_t prog_st_ff, nxt_prog_st;

  assign sensor_address_field = pay_ff[2:0];
  assign fc = pay_ff[5:3];
  assign na = pay_ff[11:6];
  assign bidx = na[5:1];
  // the function reads the array; a continuous assign would miss updates
  always_comb begin
    cur = rd_byte(bidx);
  end
  assign merged = na[0] ? {pay_ff[15:12], cur[3:0]} :
                          {cur[7:4], pay_ff[15:12]};
  assign in_range = int'(bidx) < ARRAY_BYTES;
  assign locked = otp_ff[`LOCK_BYTE][`LOCK_BIT];

  always_comb begin
    dec_n = 2'd0;
    dec_w0 = `RC_OK;
    dec_w1 = 10'h000;
    dec_w2 = 10'h000;
    err = 1'b0;
    error_number = `ERR_FRAMING;
    wr_en = 1'b0;
    exec_go = 1'b0;
    if (frame_done) begin
      if (fail_ff || start_ff != `START_SEQ ||
          (pos_ff < `LONG_LEN && pos_ff != `SHORT_LEN)) begin
        err = 1'b1;
        dec_n = 2'd2;
      end else if (pos_ff > `LONG_LEN) begin
        dec_n = 2'd0;
      end else if (crc_rem != 3'h0) begin
        err = 1'b1;
        error_number = `ERR_CRC;
        dec_n = (pos_ff == `SHORT_LEN) ? 2'd2 : 2'd3;
      end else if (sensor_address_field != `OWN_SENSOR_ADDRESS_FIELD) begin
        dec_n = 2'd0;
      end else if (pos_ff == `SHORT_LEN) begin
        case (fc)
          `FC_EXEC: begin
            dec_n = 2'd2;
            if (locked || prog_st_ff != P_IDLE) begin
              err = 1'b1;
              error_number = `ERR_WPROT;
            end else begin
              dec_w1 = `WORD_EXEC_OK;
              exec_go = 1'b1;
            end
          end
          `FC_ENTRY: begin
            dec_n = 2'd2;
            dec_w1 = `WORD_ENTRY_OK;
          end
          default: begin
            dec_n = 2'd0;
          end
        endcase
      end else begin
        case (fc)
          `FC_READ: begin
            dec_n = 2'd3;
            if (!in_range) begin
              err = 1'b1;
              error_number = `ERR_RANGE;
            end else begin
              dec_w1 = {2'b00, cur};
              if (int'(bidx) == ARRAY_BYTES - 1) begin
                dec_w2 = 10'h000;
              end else begin
                dec_w2 = {2'b00, rd_byte(bidx + 5'h01)};
              end
            end
          end
          `FC_WRITE: begin
            dec_n = 2'd3;
            if (!in_range) begin
              err = 1'b1;
              error_number = `ERR_RANGE;
            end else if (locked || bidx == `STATUS_BYTE) begin
              err = 1'b1;
              error_number = `ERR_WPROT;
            end else begin
              wr_en = 1'b1;
              dec_w1 = {2'b00, merged};
              dec_w2 = {4'h0, na};
            end
          end
          default: begin
            dec_n = 2'd0;
          end
        endcase
      end
      if (err) begin
        dec_w0 = `RC_ERR;
        dec_w1 = {6'h00, error_number};
        dec_w2 = 10'h000;
      end
    end
  end

  // -----------------------------------------------------------------
  // array and otp programming
  // -----------------------------------------------------------------
  logic [31:0] timer_ff, nxt_timer;
  logic [15:0] ones_ff, nxt_ones;

  always_comb begin
    nxt_shadow = shadow_ff;
    nxt_otp = otp_ff;
    nxt_valid = valid_ff;
    nxt_prog_st = prog_st_ff;
    nxt_timer = timer_ff;
    nxt_ones = ones_ff;
    if (wr_en) begin
      nxt_shadow[bidx[AW-1:0]] = merged;
    end
    case (prog_st_ff)
      P_IDLE: begin
        if (exec_go) begin
          nxt_prog_st = P_DELAY;
          nxt_timer = 32'h0000_0000;
        end
      end
      P_DELAY: begin
        if (timer_ff == 32'(PROG_DELAY_CYC - 1)) begin
          nxt_timer = 32'h0000_0000;
          nxt_ones = ones_needed();
          // without programming voltage the attempt fails quietly
          nxt_prog_st = vpp_ok_i ? P_WRITE : P_IDLE;
        end else begin
          nxt_timer = timer_ff + 32'h0000_0001;
        end
      end
      P_WRITE: begin
        if (ones_ff == 16'h0000) begin
          nxt_prog_st = P_DONE;
        end else if (timer_ff == 32'(PROG_BIT_CYC - 1)) begin
          nxt_timer = 32'h0000_0000;
          nxt_ones = ones_ff - 16'h0001;
        end else begin
          nxt_timer = timer_ff + 32'h0000_0001;
        end
      end
      P_DONE: begin
        for (int i = 0; i < ARRAY_BYTES; i++) begin
          nxt_otp[i] = otp_ff[i] | shadow_ff[i];
          nxt_shadow[i] = otp_ff[i] | shadow_ff[i];
        end
        nxt_valid = 1'b1;
        nxt_prog_st = P_IDLE;
      end
      default: begin
        nxt_prog_st = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
        shadow_ff[i] <= `SHADOW_RST;
        otp_ff[i] <= `SHADOW_RST;
      end
      valid_ff <= 1'b0;
      prog_st_ff <= P_IDLE;
      timer_ff <= 32'h0000_0000;
      ones_ff <= 16'h0000;
    end else begin
      shadow_ff <= nxt_shadow;
      otp_ff <= nxt_otp;
      valid_ff <= nxt_valid;
      prog_st_ff <= nxt_prog_st;
      timer_ff <= nxt_timer;
      ones_ff <= nxt_ones;
    end
  end

  // -----------------------------------------------------------------
  // response sequencing
  // -----------------------------------------------------------------
  resp_word_t resp_w_ff [3];
  resp_word_t nxt_resp_w [3];
  logic [1:0] left_ff, nxt_left, ptr_ff, nxt_ptr;
  logic tx_start_ff, nxt_tx_start, tx_par_ff, nxt_tx_par;
  resp_word_t tx_word_ff, nxt_tx_word;
  logic busy;

  assign busy = prog_st_ff == P_WRITE || prog_st_ff == P_DONE;

  always_comb begin
    nxt_resp_w = resp_w_ff;
    nxt_left = left_ff;
    nxt_ptr = ptr_ff;
    nxt_tx_start = 1'b0;
    nxt_tx_word = tx_word_ff;
    nxt_tx_par = tx_par_ff;
    if (dec_n != 2'd0) begin
      nxt_resp_w[0] = dec_w0;
      nxt_resp_w[1] = dec_w1;
      nxt_resp_w[2] = dec_w2;
      nxt_left = dec_n;
      nxt_ptr = 2'd0;
    end else if (sync_pulse_i && left_ff != 2'd0 && !busy) begin
      // one word per sync; none while writing
      nxt_tx_start = 1'b1;
      nxt_tx_word = resp_w_ff[ptr_ff];
      nxt_tx_par = ^resp_w_ff[ptr_ff];
      nxt_ptr = ptr_ff + 2'd1;
      nxt_left = left_ff - 2'd1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 3; i++) begin
        resp_w_ff[i] <= 10'h000;
      end
      left_ff <= 2'd0;
      ptr_ff <= 2'd0;
      tx_start_ff <= 1'b0;
      tx_word_ff <= 10'h000;
      tx_par_ff <= 1'b0;
    end else begin
      resp_w_ff <= nxt_resp_w;
      left_ff <= nxt_left;
      ptr_ff <= nxt_ptr;
      tx_start_ff <= nxt_tx_start;
      tx_word_ff <= nxt_tx_word;
      tx_par_ff <= nxt_tx_par;
    end
  end

  assign tx_start_o = tx_start_ff;
  assign tx_word_o = tx_word_ff;
  assign tx_parity_o = tx_par_ff;
  assign prog_busy_o = prog_st_ff != P_IDLE;
  assign otp_valid_flag_o = valid_ff;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_first_is_code;
    tx_start_ff && $past(ptr_ff) == 2'd0 |->
      (tx_word_ff == `RC_OK || tx_word_ff == `RC_ERR);
  endproperty
  a_first_is_code: assert property (p_first_is_code)
    else $error("first response word is not a response code");

  property p_silent_write;
    prog_st_ff == P_WRITE |=> !tx_start_ff;
  endproperty
  a_silent_write: assert property (p_silent_write)
    else $error("word sent during otp write");

  property p_entry_resp;
    frame_done && !err && dec_n != 2'd0 && pos_ff == `SHORT_LEN &&
      fc == `FC_ENTRY |=> resp_w_ff[0] == `RC_OK &&
      resp_w_ff[1] == `WORD_ENTRY_OK && left_ff == 2'd2;
  endproperty
  a_entry_resp: assert property (p_entry_resp)
    else $error("entry answer wrong");

  sequence s_delay_end;
    prog_st_ff == P_DELAY ##1 prog_st_ff == P_WRITE;
  endsequence
  property p_start_delay;
    s_delay_end |-> $past(timer_ff) == 32'(PROG_DELAY_CYC - 1);
  endproperty
  a_start_delay: assert property (p_start_delay)
    else $error("programming started before delay elapsed");

  property p_err_zero;
    resp_w_ff[0] == `RC_ERR |->
      resp_w_ff[1][9:4] == 6'h00 && resp_w_ff[2] == 10'h000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("nonzero bits around error number");

  property p_error_number_set;
    resp_w_ff[0] == `RC_ERR |-> resp_w_ff[1][3:0] inside
      {`ERR_FRAMING, `ERR_CRC, `ERR_RANGE, `ERR_WPROT};
  endproperty
  a_error_number_set: assert property (p_error_number_set)
    else $error("unsupported error number");

  property p_valid_set;
    prog_st_ff == P_DONE |=> valid_ff && prog_st_ff == P_IDLE;
  endproperty
  a_valid_set: assert property (p_valid_set)
    else $error("otp-valid flag not set on completion");

  property p_parity;
    tx_start_ff |-> ^{tx_word_ff, tx_par_ff} == 1'b0;
  endproperty
  a_parity: assert property (p_parity)
    else $error("odd parity on response word");
endmodule

// [cmd_master.sv]
// command master model: frames command bits and asks for response words
// assumes the responder samples its inputs on the rising clock edge
`timescale 1ns/1ps
`include "prog_resp_defines.svh"
module cmd_master (
  input wire logic core_clk_i,
  output logic cmd_bit_valid_o,
  output logic cmd_bit_o,
  output logic sync_pulse_o
);
  initial begin
    cmd_bit_valid_o = 1'b0;
    cmd_bit_o = 1'b0;
    sync_pulse_o = 1'b0;
  end

  task automatic drive(input logic b);
    cmd_bit_valid_o <= 1'b1;
    cmd_bit_o <= b;
    @(posedge core_clk_i);
  endtask

  // -----------------------------------------------------------------
  // command frame; bad 1 crc, bad 2 last sync low, bad 3 one extra bit
  // -----------------------------------------------------------------
  task automatic send(input logic [2:0] sa, input logic [2:0] fc,
                      input logic lng, input logic [5:0] ra,
                      input logic [3:0] d, input logic [1:0] bad);
    logic [21:0] q;
    logic [2:0] r;
    logic b;
    int n;
    q = '0;
    q[1] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      q[3 + i] = sa[i];
      q[6 + i] = fc[i];
    end
    for (int i = 0; i < 6; i++) begin
      q[9 + i] = ra[i];
    end
    for (int i = 0; i < 4; i++) begin
      q[15 + i] = d[i];
    end
    n = lng ? 19 : 9;
    // seeded crc over payload and three zeros
    r = `CRC_SEED;
    for (int k = 3; k < n + 3; k++) begin
      b = (k < n) ? q[k] : 1'b0;
      r = {r[1:0], b} ^ (r[2] ? `CRC_POLY : 3'h0);
    end
    q[n] = r[2] ^ (bad == 2'h1);
    q[n + 1] = r[1];
    q[n + 2] = r[0];
    // one sync bit between successive groups of three message bits
    for (int k = 0; k < n + 3; k++) begin
      if (k > 0 && k % 3 == 0) begin
        // the last sync bit of a frame always sits at or after index n
        drive(!(bad == 2'h2 && k >= n));
      end
      drive(q[k]);
    end
    if (bad == 2'h3) begin
      drive(1'b1);
    end
    // released line shows the inverse, not the last bit
    cmd_bit_valid_o <= 1'b0;
    cmd_bit_o <= ~cmd_bit_o;
    repeat (`GAP_CYC + 4) @(posedge core_clk_i);
  endtask

  // syncs only when the tests ask, never while writing otp
  task automatic pulse();
    sync_pulse_o <= 1'b1;
    @(posedge core_clk_i);
    sync_pulse_o <= 1'b0;
  endtask
endmodule

// [tb.sv]
// self-checking bench of the programming-mode command responder
// assumes the command master model drives the command and sync inputs
`timescale 1ns/1ps
`include "prog_resp_defines.svh"
module tb;
  import prog_resp_pkg::*;
  // long enough start delay that both answer words leave before writing
  localparam int PD = 40;
  localparam int PB = 20;
  // one bits loaded into the shadows by t_rw and t_prog before execute
  localparam int ONES = 7;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic vpp_ok_i = 1'b0;
  logic cmd_bit_valid_i;
  logic cmd_bit_i;
  logic sync_pulse_i;
  logic tx_start_o;
  logic [9:0] tx_word_o;
  logic tx_parity_o;
  logic prog_busy_o;
  logic otp_valid_flag_o;
  int error_cnt = 0;
  int checks_done = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  cmd_master master (
    .core_clk_i(core_clk_i),
    .cmd_bit_valid_o(cmd_bit_valid_i),
    .cmd_bit_o(cmd_bit_i),
    .sync_pulse_o(sync_pulse_i)
  );

  prog_mode_command_responder #(
    .PROG_DELAY_CYC(PD),
    .PROG_BIT_CYC(PB)
  ) DUT (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .cmd_bit_valid_i(cmd_bit_valid_i),
    .cmd_bit_i(cmd_bit_i),
    .sync_pulse_i(sync_pulse_i),
    .vpp_ok_i(vpp_ok_i),
    .tx_start_o(tx_start_o),
    .tx_word_o(tx_word_o),
    .tx_parity_o(tx_parity_o),
    .prog_busy_o(prog_busy_o),
    .otp_valid_flag_o(otp_valid_flag_o)
  );

  // -----------------------------------------------------------------
  // shared checking tasks
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [9:0] seen,
                     input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic word(input logic [9:0] exp);
    logic got;
    got = 1'b0;
    master.pulse();
    for (int i = 0; i < 4 && !got; i++) begin
      #1;
      got = (tx_start_o === 1'b1);
      if (!got) @(posedge core_clk_i);
    end
    chk("tx_start", {9'h000, got}, 10'h001);
    chk("tx_word", tx_word_o, exp);
    chk("tx_parity", {9'h000, tx_parity_o}, {9'h000, ^exp});
    @(posedge core_clk_i);
  endtask

  task automatic quiet();
    master.pulse();
    repeat (4) begin
      #1;
      chk("no_answer", {9'h000, tx_start_o}, 10'h000);
      @(posedge core_clk_i);
    end
  endtask

  task automatic xfer(input logic [2:0] fc, input logic lng,
                      input logic [5:0] ra, input logic [3:0] d,
                      input logic [1:0] bad, input logic [9:0] rc,
                      input logic [9:0] w1, input logic [9:0] w2);
    master.send(3'h1, fc, lng, ra, d, bad);
    word(rc);
    word(w1);
    if (lng && bad != 2'h2) word(w2);
    quiet();
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_entry();
    xfer(`FC_ENTRY, 1'b0, 6'h00, 4'h0, 2'h0,
         `RC_OK, 10'h0ca, 10'h000);
  endtask

  // last entry is one bit too long: an answerable read that must stay silent
  task automatic t_silent();
    logic [2:0] sa_t [5] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h1};
    logic [2:0] fc_t [5] = '{3'h5, 3'h6, 3'h7, 3'h0, 3'h2};
    logic lng_t [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [1:0] bad_t [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3};
    for (int i = 0; i < 5; i++) begin
      master.send(sa_t[i], fc_t[i], lng_t[i], 6'h04, 4'h1, bad_t[i]);
      quiet();
    end
  endtask

  task automatic t_rw();
    xfer(`FC_WRITE, 1'b1, 6'h05, 4'ha, 2'h0,
         `RC_OK, 10'h0a0, 10'h005);
    xfer(`FC_WRITE, 1'b1, 6'h06, 4'h3, 2'h0,
         `RC_OK, 10'h003, 10'h006);
    xfer(`FC_READ, 1'b1, 6'h04, 4'h0, 2'h0,
         `RC_OK, 10'h0a0, 10'h003);
    xfer(`FC_WRITE, 1'b1, 6'h1f, 4'hc, 2'h0,
         `RC_OK, 10'h0c0, 10'h01f);
    xfer(`FC_READ, 1'b1, 6'h1e, 4'h0, 2'h0,
         `RC_OK, 10'h0c0, 10'h000);
  endtask

  task automatic t_err();
    xfer(`FC_READ, 1'b1, 6'h20, 4'h0, 2'h0,
         `RC_ERR, 10'h005, 10'h000);
    xfer(`FC_WRITE, 1'b1, 6'h00, 4'h1, 2'h0,
         `RC_ERR, 10'h006, 10'h000);
    xfer(`FC_ENTRY, 1'b0, 6'h00, 4'h0, 2'h1,
         `RC_ERR, 10'h002, 10'h000);
    xfer(`FC_ENTRY, 1'b0, 6'h00, 4'h0, 2'h2,
         `RC_ERR, 10'h001, 10'h000);
  endtask

  task automatic t_prog();
    int c;
    c = 0;
    // load a shadow byte, then execute
    xfer(`FC_WRITE, 1'b1, 6'h02, 4'h1, 2'h0,
         `RC_OK, 10'h001, 10'h002);
    vpp_ok_i <= 1'b1;
    xfer(`FC_EXEC, 1'b0, 6'h00, 4'h0, 2'h0,
         `RC_OK, 10'h2aa, 10'h000);
    // look past the edge so the state update has settled
    #1;
    while (prog_busy_o === 1'b1 && c < 1000) begin
      c++;
      @(posedge core_clk_i);
      #1;
    end
    // about 13 busy cycles pass inside the answer exchange
    chk("busy_len", {9'h000, (c >= PD + ONES * PB - 16 &&
        c <= PD + ONES * PB + 4)}, 10'h001);
    chk("otp_valid", {9'h000, otp_valid_flag_o}, 10'h001);
    @(posedge core_clk_i);
    // read back status and refreshed shadow byte
    xfer(`FC_READ, 1'b1, 6'h00, 4'h0, 2'h0,
         `RC_OK, 10'h001, 10'h001);
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    t_entry();
    t_silent();
    t_rw();
    t_err();
    t_prog();
    print_verdict();
  end

  // about 18 frames of some 1330 cycles each are expected
  initial begin
    repeat (60000) @(posedge core_clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule
